/* File: rtl/sra_consts.vh */
// constants for the special register access unit
`ifndef SRA_CONSTS_VH
`define SRA_CONSTS_VH

// =====================================
// instruction operation codes
`define OP_CHANGE_STATE 2'h0
`define OP_READ_SPECIAL 2'h1
`define OP_WRITE_SPECIAL 2'h2
`define OP_WRITE_SPECIAL_IMM 2'h3

// =====================================
// select code groups and low codes
`define GRP_STATUS 5'h00
`define GRP_STACK 5'h01
`define GRP_MASKCTL 5'h02
`define LOW_MAIN_SP 3'h0
`define LOW_PROC_SP 3'h1
`define LOW_MASK 3'h0
`define LOW_CONTROL 3'h4

// =====================================
// register numbers that may not be used
`define GPR_STACK_PTR 4'hd
`define GPR_PROG_CNT 4'hf

// =====================================
// field positions
`define ACTIVE_EXCEPTION_STATUS_MSB 8
`define FLAGS_MSB 31
`define FLAGS_LSB 27
`define SP_LSB 2

// =====================================
// register port offsets
`define REG_CONFIG 2'h0
`define REG_STATUS 2'h1
`define REG_UNPRED_COUNT 2'h2

// =====================================
// reset values
`define CONFIG_RESET 1'h1
`define SP_RESET 32'h0000_0000
`define FLAGS_RESET 5'h00

`endif

/* File: rtl/special_register_access_unit.v */
// special register access unit: mask, read and write special instructions
// How it works
// - immediate form of write special is reported undefined
// - change state enable form clears mask bit, disable form sets it
// - mask bit at one raises execution priority to zero
// - change state updates mask only when privileged
// - change state raise is serialized; lowering seen after barrier or exception
// - read special with register 13 or 15 or bad select is unpredictable
// - read zeroes destination; status group merges exception number and flags
// - stack group reads main or process stack pointer
// - mask group reads mask bit or two control bits
// - unprivileged read of stack pointers or exception status gives zero
// - execution status bits always read as zero
// - write special bad register or select unpredictable; else status group codes with bit 2 clear write flags
// - privileged stack pointer write drops two low bits
// - privileged mask group low code 000 loads mask bit
// - privileged control write works only in thread mode
// - with privilege extension unprivileged thread writes are ignored, except flag writes
// - writing the unprivileged bit switches thread to unprivileged
// - exception and execution status are read only
// - write special raise is serialized; lowering seen after barrier
`timescale 1ns/1ns
`include "sra_consts.vh"

// =====================================
// instruction port
// one instruction is taken at each edge where instruction valid is high
// operation 0 change state, 1 read special, 2 write special, 3 immediate form
// select bits 7:3 pick the group, bits 2:0 the low code
// register number is the destination of a read or the source of a write
// results, fault pulses and flag writes appear one cycle after the take
// reads see state as it stood before the edge that takes them
// back to back instructions are fine, no wait is ever inserted
// an unpredictable or undefined encoding changes no state other than the unpredictable count
//
// =====================================
// select codes
// status group: any low code but 4; flags, exception number, both, or neither for code 6
// stack group: low code 0 main, 1 process
// mask group: low code 0 mask bit, 4 control bits
// all other codes are unpredictable
//
// =====================================
// privilege
// handler mode always counts as privileged
// thread mode is privileged while the unprivileged bit is clear
// with the privilege extension switched off all code is privileged
//
// =====================================
// priority
// priority zero follows the mask bit at once when the mask is set
// a cleared mask lowers priority only at the next sync event
// sync marks a barrier, an exception entry or an exception return
// serialize pulses for one cycle whenever priority is raised
//
// =====================================
// reset
// reset is asynchronous and active high
// mask, control bits, stack pointers and all pulses clear
// the privilege extension comes up present
// the first instruction may follow the first edge after release
//
// =====================================
// register port map
// offset 0 config: bit 0 privilege extension present, reset 1
// offset 1 status, read only:
//   bit 0 mask bit
//   bit 1 unprivileged bit
//   bit 2 stack select bit
//   bit 3 priority held at zero
//   bit 4 current execution privileged
//   bit 5 priority lowering waits for sync
// offset 2 unpredictable count, any write clears it
// offset 3 unmapped, reads zero and ignores writes
// read data stand only in the cycle after the read strobe

module special_register_access_unit #(
    parameter COUNT_WIDTH = 16
) (
    input wire CLK,
    input wire RESET,
    input wire INSTR_VALID,
    input wire [1:0] INSTR_OP,
    input wire CPS_DISABLE,
    input wire [7:0] SPECIAL_REG_SELECT,
    input wire [3:0] GPR_NUM,
    input wire [31:0] SOURCE_GPR,
    input wire HANDLER_MODE,
    input wire [8:0] ACTIVE_EXCEPTION_STATUS,
    input wire [4:0] ARITHMETIC_FLAGS_STATUS,
    input wire SYNC_EVENT,
    input wire [1:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    output reg RESULT_VALID,
    output reg [3:0] RESULT_GPR,
    output reg [31:0] RESULT_DATA,
    output reg UNPREDICTABLE,
    output reg UNDEFINED,
    output reg FLAGS_WE,
    output reg [4:0] FLAGS_WDATA,
    output reg MASK_BIT,
    output reg PRIORITY_ZERO,
    output reg SERIALIZE,
    output reg STACK_SELECT_BIT,
    output reg UNPRIVILEGED_BIT,
    output reg [31:0] MAIN_STACK_POINTER,
    output reg [31:0] PROCESS_STACK_POINTER
);

// =====================================
// state
reg priv_ext_reg;
reg lower_pending_reg;
reg [COUNT_WIDTH-1:0] unpred_count_reg;

reg mask_next;
reg stack_select_bit_next;
reg unpriv_next;
reg [31:0] msp_next;
reg [31:0] psp_next;
reg flags_we_next;
reg [4:0] flags_next;
reg [31:0] rd_next;
reg res_valid_next;
reg unpred_next;
reg undef_next;
reg boost_next;
reg serialize_next;
reg pending_next;

wire [4:0] grp = SPECIAL_REG_SELECT[7:3];
wire [2:0] low = SPECIAL_REG_SELECT[2:0];
wire privileged = HANDLER_MODE | ~priv_ext_reg | ~UNPRIVILEGED_BIT;
wire bad_gpr = (GPR_NUM == `GPR_STACK_PTR) | (GPR_NUM == `GPR_PROG_CNT);

// supported select codes
reg select_ok;
always @* begin
    case (grp)
        `GRP_STATUS: select_ok = (low != 3'h4);
        `GRP_STACK: select_ok = (low == `LOW_MAIN_SP) | (low == `LOW_PROC_SP);
        `GRP_MASKCTL: select_ok = (low == `LOW_MASK) | (low == `LOW_CONTROL);
        default: select_ok = 1'b0;
    endcase
end

wire is_cps = INSTR_VALID & (INSTR_OP == `OP_CHANGE_STATE);
wire is_mrs = INSTR_VALID & (INSTR_OP == `OP_READ_SPECIAL);
wire is_msr = INSTR_VALID & (INSTR_OP == `OP_WRITE_SPECIAL);
wire is_imm = INSTR_VALID & (INSTR_OP == `OP_WRITE_SPECIAL_IMM);
wire bad_special = (is_mrs | is_msr) & (bad_gpr | ~select_ok);

// =====================================
// instruction execution
always @* begin
    mask_next = MASK_BIT;
    stack_select_bit_next = STACK_SELECT_BIT;
    unpriv_next = UNPRIVILEGED_BIT;
    msp_next = MAIN_STACK_POINTER;
    psp_next = PROCESS_STACK_POINTER;
    flags_we_next = 1'b0;
    flags_next = FLAGS_WDATA;
    rd_next = 32'h0000_0000;
    res_valid_next = 1'b0;
    undef_next = is_imm;
    unpred_next = bad_special;
    if (is_cps && privileged) begin
        mask_next = CPS_DISABLE;
    end
    if (is_mrs && !bad_special) begin
        res_valid_next = 1'b1;
        case (grp)
            `GRP_STATUS: begin
                if (low[0] && privileged) begin
                    rd_next[`ACTIVE_EXCEPTION_STATUS_MSB:0] = ACTIVE_EXCEPTION_STATUS;
                end
                if (!low[2]) begin
                    rd_next[`FLAGS_MSB:`FLAGS_LSB] = ARITHMETIC_FLAGS_STATUS;
                end
            end
            `GRP_STACK: begin
                if (privileged && low == `LOW_MAIN_SP) begin
                    rd_next = MAIN_STACK_POINTER;
                end
                if (privileged && low == `LOW_PROC_SP) begin
                    rd_next = PROCESS_STACK_POINTER;
                end
            end
            default: begin
                if (low == `LOW_MASK) begin
                    rd_next[0] = MASK_BIT;
                end
                if (low == `LOW_CONTROL) begin
                    rd_next[1:0] = {STACK_SELECT_BIT, UNPRIVILEGED_BIT};
                end
            end
        endcase
    end
    if (is_msr && !bad_special) begin
        case (grp)
            `GRP_STATUS: begin
                if (!low[2]) begin
                    flags_we_next = 1'b1;
                    flags_next = SOURCE_GPR[`FLAGS_MSB:`FLAGS_LSB];
                end
            end
            `GRP_STACK: begin
                if (privileged && low == `LOW_MAIN_SP) begin
                    msp_next = {SOURCE_GPR[31:`SP_LSB], 2'b00};
                end
                if (privileged && low == `LOW_PROC_SP) begin
                    psp_next = {SOURCE_GPR[31:`SP_LSB], 2'b00};
                end
            end
            default: begin
                if (privileged && low == `LOW_MASK) begin
                    mask_next = SOURCE_GPR[0];
                end
                if (privileged && low == `LOW_CONTROL && !HANDLER_MODE) begin
                    stack_select_bit_next = SOURCE_GPR[1];
                    unpriv_next = SOURCE_GPR[0];
                end
            end
        endcase
    end
end

// =====================================
// priority visibility
always @* begin
    boost_next = PRIORITY_ZERO;
    pending_next = lower_pending_reg;
    serialize_next = 1'b0;
    if (mask_next && !MASK_BIT) begin
        boost_next = 1'b1;
        pending_next = 1'b0;
        serialize_next = 1'b1;
    end else if (!mask_next && MASK_BIT) begin
        pending_next = 1'b1;
    end
    // a raise in the same cycle keeps priority at zero
    // lowering waits for sync
    if (SYNC_EVENT && !(mask_next && !MASK_BIT)) begin
        boost_next = mask_next;
        pending_next = 1'b0;
    end
    if (mask_next) begin
        boost_next = 1'b1;
    end
end

// =====================================
// mask and priority state
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        MASK_BIT <= 1'b0;
        PRIORITY_ZERO <= 1'b0;
        lower_pending_reg <= 1'b0;
        SERIALIZE <= 1'b0;
    end else begin
        MASK_BIT <= mask_next;
        PRIORITY_ZERO <= boost_next;
        lower_pending_reg <= pending_next;
        SERIALIZE <= serialize_next;
    end
end

// =====================================
// control bits and stack pointers
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        STACK_SELECT_BIT <= 1'b0;
        UNPRIVILEGED_BIT <= 1'b0;
        MAIN_STACK_POINTER <= `SP_RESET;
        PROCESS_STACK_POINTER <= `SP_RESET;
    end else begin
        STACK_SELECT_BIT <= stack_select_bit_next;
        UNPRIVILEGED_BIT <= unpriv_next;
        MAIN_STACK_POINTER <= msp_next;
        PROCESS_STACK_POINTER <= psp_next;
    end
end

// =====================================
// flag write to the core
// flag data hold their last value, only the strobe qualifies them
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        FLAGS_WE <= 1'b0;
        FLAGS_WDATA <= `FLAGS_RESET;
    end else begin
        FLAGS_WE <= flags_we_next;
        FLAGS_WDATA <= flags_next;
    end
end

// =====================================
// instruction results
// destination number follows every instruction, the valid pulse qualifies it
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        RESULT_VALID <= 1'b0;
        RESULT_GPR <= 4'h0;
        RESULT_DATA <= 32'h0000_0000;
        UNPREDICTABLE <= 1'b0;
        UNDEFINED <= 1'b0;
    end else begin
        RESULT_VALID <= res_valid_next;
        RESULT_GPR <= GPR_NUM;
        RESULT_DATA <= rd_next;
        UNPREDICTABLE <= unpred_next;
        UNDEFINED <= undef_next;
    end
end

// =====================================
// register port: privilege extension switch
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        priv_ext_reg <= `CONFIG_RESET;
    end else if (REG_WR && REG_ADDR == `REG_CONFIG) begin
        priv_ext_reg <= REG_WDATA[0];
    end
end

// =====================================
// register port: unpredictable count
// a clear in the cycle of a new event wins, that event is not counted
// the count wraps at its width
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        unpred_count_reg <= {COUNT_WIDTH{1'b0}};
    end else if (REG_WR && REG_ADDR == `REG_UNPRED_COUNT) begin
        unpred_count_reg <= {COUNT_WIDTH{1'b0}};
    end else if (bad_special) begin
        unpred_count_reg <= unpred_count_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
    end
end

// =====================================
// register port: read data
// read data stand one cycle only and are zero otherwise
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
        case (REG_ADDR)
            `REG_CONFIG: REG_RDATA <= {{31{1'b0}}, priv_ext_reg};
            `REG_STATUS: REG_RDATA <= {{26{1'b0}}, lower_pending_reg,
                privileged, PRIORITY_ZERO, STACK_SELECT_BIT,
                UNPRIVILEGED_BIT, MASK_BIT};
            `REG_UNPRED_COUNT: REG_RDATA <= {{(32-COUNT_WIDTH){1'b0}},
                unpred_count_reg};
            default: REG_RDATA <= 32'h0000_0000;
        endcase
    end else begin
        REG_RDATA <= 32'h0000_0000;
    end
end

endmodule // special_register_access_unit

/* File: test/core_flags_model.sv */
// core flag store that takes flag writes from the unit
`timescale 1ns/1ns
module core_flags_model (
    input wire CLK,
    input wire RESET,
    input wire FLAGS_WE,
    input wire [4:0] FLAGS_WDATA,
    output reg [4:0] ARITHMETIC_FLAGS_STATUS
);
    // ====================
    // flag register
    always @(posedge CLK or posedge RESET) begin
        if (RESET)
            ARITHMETIC_FLAGS_STATUS <= 5'h00;
        else if (FLAGS_WE)
            ARITHMETIC_FLAGS_STATUS <= FLAGS_WDATA;
    end
endmodule // core_flags_model

/* File: test/sra_checker_sva.sv */
// assertion checker for the special register access unit
`timescale 1ns/1ns
module sra_checker #(
    parameter COUNT_WIDTH = 16
) (
    input wire CLK,
    input wire RESET,
    input wire INSTR_VALID,
    input wire [1:0] INSTR_OP,
    input wire CPS_DISABLE,
    input wire [7:0] SPECIAL_REG_SELECT,
    input wire [3:0] GPR_NUM,
    input wire [31:0] SOURCE_GPR,
    input wire HANDLER_MODE,
    input wire SYNC_EVENT,
    input wire UNDEFINED,
    input wire UNPREDICTABLE,
    input wire RESULT_VALID,
    input wire MASK_BIT,
    input wire PRIORITY_ZERO,
    input wire SERIALIZE,
    input wire UNPRIVILEGED_BIT,
    input wire [31:0] MAIN_STACK_POINTER,
    input wire REG_WR,
    input wire [1:0] REG_ADDR,
    input wire [31:0] REG_WDATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    wire change_state_instr = INSTR_VALID && INSTR_OP == 2'h0;
    // mirror of the privilege extension switch
    reg ext_on;
    always @(posedge CLK or posedge RESET) begin
        if (RESET)
            ext_on <= 1'b1;
        else if (REG_WR && REG_ADDR == 2'h0)
            ext_on <= REG_WDATA[0];
    end
    // ====================
    // properties
    property p_undef; INSTR_VALID && INSTR_OP == 2'h3 |=> UNDEFINED; endproperty
    a_undef: assert property (p_undef) else $error("immediate form not undefined");
    property p_cps; change_state_instr && HANDLER_MODE |=> MASK_BIT == $past(CPS_DISABLE); endproperty
    a_cps: assert property (p_cps) else $error("change state gave wrong mask");
    property p_prio; MASK_BIT |-> PRIORITY_ZERO; endproperty
    a_prio: assert property (p_prio) else $error("mask set without priority zero");
    property p_unpriv; change_state_instr && !HANDLER_MODE && UNPRIVILEGED_BIT && ext_on |=> $stable(MASK_BIT);
    endproperty
    a_unpriv: assert property (p_unpriv) else $error("unprivileged mask change");
    property p_ser; $rose(PRIORITY_ZERO) |-> SERIALIZE; endproperty
    a_ser: assert property (p_ser) else $error("raise not serialized");
    property p_hold; $fell(MASK_BIT) && !$past(SYNC_EVENT) |-> PRIORITY_ZERO; endproperty
    a_hold: assert property (p_hold) else $error("priority dropped early");
    property p_sync; PRIORITY_ZERO && !MASK_BIT && SYNC_EVENT && !INSTR_VALID |=> !PRIORITY_ZERO;
    endproperty
    a_sync: assert property (p_sync) else $error("priority kept after sync");
    property p_badreg; INSTR_VALID && INSTR_OP == 2'h1 && (GPR_NUM == 4'hd || GPR_NUM == 4'hf)
        |=> UNPREDICTABLE && !RESULT_VALID; endproperty
    a_badreg: assert property (p_badreg) else $error("bad destination accepted");
    property p_msp; INSTR_VALID && INSTR_OP == 2'h2 && HANDLER_MODE && SPECIAL_REG_SELECT == 8'h08
        && GPR_NUM < 4'hd |=> MAIN_STACK_POINTER == {$past(SOURCE_GPR[31:2]), 2'b00}; endproperty
    a_msp: assert property (p_msp) else $error("stack pointer load wrong");
    property p_noexc; INSTR_VALID && INSTR_OP != 2'h3 |=> !UNDEFINED; endproperty
    a_noexc: assert property (p_noexc) else $error("spurious undefined");
endmodule // sra_checker

bind special_register_access_unit sra_checker #(.COUNT_WIDTH(COUNT_WIDTH)) sra_checker_i (.*);

/* File: test/tb_top.sv */
// self-checking bench for the special register access unit
`timescale 1ns/1ns
module tb_top;
    reg CLK = 0, RESET = 1, INSTR_VALID = 0, CPS_DISABLE = 0, HANDLER_MODE = 0;
    reg SYNC_EVENT = 0, REG_WR = 0, REG_RD = 0;
    reg [1:0] INSTR_OP = 0, REG_ADDR = 0;
    reg [7:0] SPECIAL_REG_SELECT = 0;
    reg [3:0] GPR_NUM = 0;
    reg [31:0] SOURCE_GPR = 0, REG_WDATA = 0;
    wire [8:0] ACTIVE_EXCEPTION_STATUS = 9'h1a5;
    wire [31:0] REG_RDATA, RESULT_DATA, MAIN_STACK_POINTER, PROCESS_STACK_POINTER;
    wire [4:0] FLAGS_WDATA, ARITHMETIC_FLAGS_STATUS;
    wire [3:0] RESULT_GPR;
    wire RESULT_VALID, UNPREDICTABLE, UNDEFINED, FLAGS_WE, MASK_BIT, PRIORITY_ZERO;
    wire SERIALIZE, STACK_SELECT_BIT, UNPRIVILEGED_BIT;
    integer bad_count = 0, total_checks = 0, cycles = 0;
    special_register_access_unit #(.COUNT_WIDTH(16)) special_register_access_unit_i (.*);
    core_flags_model core_flags_model_i (.*);
    always #25 CLK = ~CLK;
    // ====================
    // tasks
    task chk(input [8*8:1] nm, input [39:0] seen, input [39:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task ins(input [1:0] op, input [7:0] sel, input [3:0] g, input [31:0] s);
        @(posedge CLK);
        INSTR_VALID <= 1'h1;
        INSTR_OP <= op;
        SPECIAL_REG_SELECT <= sel;
        GPR_NUM <= g;
        SOURCE_GPR <= s;
        CPS_DISABLE <= s[0];
        @(posedge CLK);
        INSTR_VALID <= 1'h0;
        #1;
    endtask
    task rg(input [1:0] a, input [31:0] e);
        @(posedge CLK);
        REG_RD <= 1'h1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'h0;
        #1 chk("regread", REG_RDATA, e);
    endtask
    task wr(input [1:0] a, input [31:0] d);
        @(posedge CLK);
        REG_WR <= 1'h1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'h0;
    endtask
    task sync;
        @(posedge CLK);
        SYNC_EVENT <= 1'h1;
        @(posedge CLK);
        SYNC_EVENT <= 1'h0;
        #1;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge CLK) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            wrap_up;
        end
    end
    // ====================
    // main sequence
    initial begin
        repeat (8) @(posedge CLK);
        RESET <= 1'h0;
        rg(2'h1, 32'h0000_0010);
        HANDLER_MODE <= 1'h1;
        ins(2'h0, 8'h00, 4'h0, 32'h0000_0001);
        chk("cpsid", {MASK_BIT, PRIORITY_ZERO, SERIALIZE}, 3'h7);
        ins(2'h0, 8'h00, 4'h0, 32'h0000_0000);
        chk("cpsie", {MASK_BIT, PRIORITY_ZERO, SERIALIZE}, 3'h2);
        sync;
        chk("prio", PRIORITY_ZERO, 1'h0);
        ins(2'h2, 8'h10, 4'h1, 32'h0000_0001);
        chk("msrmask", {MASK_BIT, PRIORITY_ZERO, SERIALIZE}, 3'h7);
        ins(2'h1, 8'h10, 4'h7, 32'h0000_0000);
        chk("rdmask", RESULT_DATA, 32'h0000_0001);
        ins(2'h2, 8'h10, 4'h1, 32'h0000_0000);
        chk("msrlow", {MASK_BIT, PRIORITY_ZERO}, 2'h1);
        sync;
        chk("prio", PRIORITY_ZERO, 1'h0);
        ins(2'h2, 8'h08, 4'h2, 32'h1234_5677);
        chk("msp", MAIN_STACK_POINTER, 32'h1234_5674);
        ins(2'h2, 8'h09, 4'h3, 32'hffff_ffff);
        chk("psp", PROCESS_STACK_POINTER, 32'hffff_fffc);
        ins(2'h1, 8'h08, 4'h2, 32'h0000_0000);
        chk("rdmsp", {RESULT_VALID, RESULT_GPR, RESULT_DATA}, 37'h1_2123_4567_4);
        ins(2'h1, 8'h09, 4'h4, 32'h0000_0000);
        chk("rdpsp", RESULT_DATA, 32'hffff_fffc);
        ins(2'h2, 8'h00, 4'h1, 32'ha800_0000);
        chk("flags", {FLAGS_WE, FLAGS_WDATA}, 6'h35);
        ins(2'h1, 8'h03, 4'h5, 32'h0000_0000);
        chk("xpsr", RESULT_DATA, 32'ha800_01a5);
        ins(2'h1, 8'h06, 4'h6, 32'h0000_0000);
        chk("execution_status", RESULT_DATA, 32'h0000_0000);
        ins(2'h2, 8'h05, 4'h1, 32'hffff_ffff);
        chk("ipsrwr", {FLAGS_WE, UNPREDICTABLE}, 2'h0);
        ins(2'h1, 8'h00, 4'hd, 32'h0000_0000);
        chk("badrd", {UNPREDICTABLE, RESULT_VALID}, 2'h2);
        ins(2'h1, 8'h04, 4'h1, 32'h0000_0000);
        chk("badsel", UNPREDICTABLE, 1'h1);
        ins(2'h2, 8'h10, 4'hf, 32'h0000_0001);
        chk("badwr", {UNPREDICTABLE, MASK_BIT}, 2'h2);
        rg(2'h2, 32'h0000_0003);
        wr(2'h2, 32'h0000_0000);
        rg(2'h2, 32'h0000_0000);
        rg(2'h3, 32'h0000_0000);
        ins(2'h3, 8'h10, 4'h1, 32'h0000_0001);
        chk("undef", {UNDEFINED, MASK_BIT}, 2'h2);
        ins(2'h2, 8'h14, 4'h1, 32'h0000_0003);
        chk("ctlhand", {STACK_SELECT_BIT, UNPRIVILEGED_BIT}, 2'h0);
        HANDLER_MODE <= 1'h0;
        ins(2'h2, 8'h14, 4'h1, 32'h0000_0003);
        chk("ctlthrd", {STACK_SELECT_BIT, UNPRIVILEGED_BIT}, 2'h3);
        sync;
        ins(2'h0, 8'h00, 4'h0, 32'h0000_0001);
        chk("upcps", MASK_BIT, 1'h0);
        ins(2'h2, 8'h08, 4'h1, 32'h0000_0000);
        chk("upmsp", MAIN_STACK_POINTER, 32'h1234_5674);
        ins(2'h1, 8'h08, 4'h2, 32'h0000_0000);
        chk("uprdsp", RESULT_DATA, 32'h0000_0000);
        ins(2'h1, 8'h05, 4'h2, 32'h0000_0000);
        chk("uprdip", RESULT_DATA, 32'h0000_0000);
        ins(2'h1, 8'h14, 4'h2, 32'h0000_0000);
        chk("rdctl", RESULT_DATA, 32'h0000_0003);
        wr(2'h0, 32'h0000_0000);
        rg(2'h0, 32'h0000_0000);
        ins(2'h0, 8'h00, 4'h0, 32'h0000_0001);
        chk("cpsoff", {MASK_BIT, PRIORITY_ZERO, SERIALIZE}, 3'h7);
        rg(2'h1, 32'h0000_001f);
        wrap_up;
    end
endmodule // tb_top
